// file: rtl/tmif_defs.svh
// Register map, field positions and reset values of the timer match flag bank.
// Assumes inclusion by bare name from the package and the bench.
`ifndef TMIF_DEFS_SVH
`define TMIF_DEFS_SVH

// Byte offsets on the register bus
`define TMIF_OFF_T0_FLAGS 12'h000
`define TMIF_OFF_T1_FLAGS 12'h004
`define TMIF_OFF_CTRL 12'h008
`define TMIF_OFF_STATUS 12'h00C
`define TMIF_OFF_MASK 12'h010

// Field positions inside a timer flag register
`define TMIF_BIT_REQ_A 5
`define TMIF_BIT_REQ_P 4
`define TMIF_BIT_EN_A 1
`define TMIF_BIT_EN_P 0

// Global interrupt enable in the control register
`define TMIF_BIT_GIE 0

// Sticky status and mask layout
`define TMIF_ST_T0_A 0
`define TMIF_ST_T0_P 1
`define TMIF_ST_T1_A 2
`define TMIF_ST_T1_P 3

// Reset values
`define TMIF_FLAGS_RST 8'h00
`define TMIF_EVT_RST 4'h0
`define TMIF_WORD_ZERO 32'h0000_0000

`endif

// file: rtl/tmif_pkg.sv
// Types shared by the timer match flag bank and its flag register.
// Assumes tmif_defs.svh is on the include path.
package tmif_pkg;
    `include "tmif_defs.svh"

    // Match events of one periodic timer
    typedef struct packed {
        logic cmp_a;
        logic cmp_p;
    } tmif_evt_t;

    // One timer flag register, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] unused_hi;
        logic cmp_a_request;
        logic cmp_p_request;
        logic [1:0] unused_mid;
        logic cmp_a_irq_en;
        logic cmp_p_irq_en;
    } tmif_flags_t;

    // Register selected by a bus address
    typedef enum logic [2:0] {
        TMIF_SEL_T0 = 3'b000,
        TMIF_SEL_T1 = 3'b001,
        TMIF_SEL_CTRL = 3'b010,
        TMIF_SEL_STAT = 3'b011,
        TMIF_SEL_MASK = 3'b100,
        TMIF_SEL_NONE = 3'b111
    } tmif_sel_t;
endpackage

// file: rtl/tmif_flag_reg.sv
// One timer flag register: two sticky match requests and two enable bits.
// Assumes events and write strobe come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tmif_flag_reg
(
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Asynchronous reset, active high
    input wire tmif_pkg::tmif_evt_t evt_i, // Match events, one-cycle pulses
    input wire logic wr_i, // Software write strobe
    input wire logic [7:0] wdata_i, // Software write data
    output var tmif_pkg::tmif_flags_t flags_o // Register contents
);
    import tmif_pkg::*;

    tmif_flags_t flags_reg;
    tmif_flags_t flags_next;

    // Software write first, then a match event sets its flag on top of it
    always_comb
    begin
        flags_next = flags_reg;
        if (wr_i)
        begin
            flags_next.cmp_a_request = wdata_i[`TMIF_BIT_REQ_A];
            flags_next.cmp_p_request = wdata_i[`TMIF_BIT_REQ_P];
            flags_next.cmp_a_irq_en = wdata_i[`TMIF_BIT_EN_A];
            flags_next.cmp_p_irq_en = wdata_i[`TMIF_BIT_EN_P];
        end
        if (evt_i.cmp_a)
        begin
            flags_next.cmp_a_request = 1'b1;
        end
        if (evt_i.cmp_p)
        begin
            flags_next.cmp_p_request = 1'b1;
        end
        flags_next.unused_hi = 2'h0;
        flags_next.unused_mid = 2'h0;
    end

    // Register the flags, cleared at reset
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            flags_reg <= `TMIF_FLAGS_RST;
        end
        else
        begin
            flags_reg <= flags_next;
        end
    end

    assign flags_o = flags_reg;
endmodule // tmif_flag_reg
`default_nettype wire

// file: rtl/tmif_match_irq_bank.sv
// Interrupt flag bank for two periodic timers, reached over an APB slave port.
// Assumes timer match events are one-cycle pulses on clk_i and the APB master
// follows the usual setup and access phases on the same clock.
//
// Functional notes
// - Timer 0 bit 5: comparator A request flag
// - Timer 0 bit 4: comparator P request flag
// - Timer 0 bit 1: comparator A interrupt enable
// - Timer 0 bit 0: comparator P interrupt enable
// - Timer 1 bit 5: comparator A request flag
// - Timer 1 bit 4: comparator P request flag
// - Timer 1 bit 1: comparator A interrupt enable
// - Timer 1 bit 0: comparator P interrupt enable
// - Bits 7 and 6 read zero, ignore writes
// - Match sets flag; vector request needs enable and global, summary interrupt needs mask only
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module tmif_match_irq_bank
(
    input wire logic clk_i, // System clock, 40 MHz
    input wire logic rst_i, // Asynchronous reset, active high
    input wire logic [11:0] paddr_i, // APB byte address
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB access phase
    input wire logic pwrite_i, // APB direction, high for write
    input wire logic [31:0] pwdata_i, // APB write data
    input wire logic [3:0] pstrb_i, // APB byte strobes
    output logic [31:0] prdata_o, // APB read data
    output logic pready_o, // APB ready
    output logic pslverr_o, // APB error on unmapped address
    input wire tmif_pkg::tmif_evt_t t0_evt_i, // Timer 0 match pulses
    input wire tmif_pkg::tmif_evt_t t1_evt_i, // Timer 1 match pulses
    output logic t0_irq_o, // Timer 0 vector request
    output logic t1_irq_o, // Timer 1 vector request
    output logic irq_o // Summary interrupt from status and mask
);
    import tmif_pkg::*;

    // Map a bus address onto a register; misaligned words miss
    function automatic tmif_sel_t addr_decode(input logic [11:0] addr);
        tmif_sel_t sel;
        case (addr)
            `TMIF_OFF_T0_FLAGS: sel = TMIF_SEL_T0;
            `TMIF_OFF_T1_FLAGS: sel = TMIF_SEL_T1;
            `TMIF_OFF_CTRL: sel = TMIF_SEL_CTRL;
            `TMIF_OFF_STATUS: sel = TMIF_SEL_STAT;
            `TMIF_OFF_MASK: sel = TMIF_SEL_MASK;
            default: sel = TMIF_SEL_NONE;
        endcase
        return sel;
    endfunction

    // Request is raised when either match is pending and enabled and the global enable is set
    function automatic logic vector_req(input tmif_flags_t f, input logic gie);
        return gie & ((f.cmp_a_request & f.cmp_a_irq_en) | (f.cmp_p_request & f.cmp_p_irq_en));
    endfunction

    // Bus phase signals
    tmif_sel_t sel;
    logic setup_phase;
    logic wr_fire;
    logic wr_t0;
    logic wr_t1;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;

    // Flag register contents
    tmif_flags_t t0_flags;
    tmif_flags_t t1_flags;

    // Bus answer state
    logic pready_reg;
    logic pready_next;
    logic pslverr_reg;
    logic pslverr_next;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;

    // Control, status and mask state
    logic gie_reg;
    logic gie_next;
    logic [3:0] status_reg;
    logic [3:0] status_next;
    logic [3:0] mask_reg;
    logic [3:0] mask_next;
    logic [3:0] evt_vec;

    // Interrupt outputs
    logic t0_irq_reg;
    logic t0_irq_next;
    logic t1_irq_reg;
    logic t1_irq_next;
    logic irq_reg;
    logic irq_next;

    // Decode and write qualification; only byte lane 0 carries the fields
    assign sel = addr_decode(paddr_i);
    assign setup_phase = psel_i & ~penable_i;
    assign wr_fire = psel_i & penable_i & pready_reg & pwrite_i & ~pslverr_reg & pstrb_i[0];
    assign wr_t0 = wr_fire & (sel == TMIF_SEL_T0);
    assign wr_t1 = wr_fire & (sel == TMIF_SEL_T1);
    assign wr_ctrl = wr_fire & (sel == TMIF_SEL_CTRL);
    assign wr_stat = wr_fire & (sel == TMIF_SEL_STAT);
    assign wr_mask = wr_fire & (sel == TMIF_SEL_MASK);

    // Timer 0 flag register
    tmif_flag_reg u_t0_flags
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .evt_i(t0_evt_i),
        .wr_i(wr_t0),
        .wdata_i(pwdata_i[7:0]),
        .flags_o(t0_flags)
    );

    // Timer 1 flag register
    tmif_flag_reg u_t1_flags
    (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .evt_i(t1_evt_i),
        .wr_i(wr_t1),
        .wdata_i(pwdata_i[7:0]),
        .flags_o(t1_flags)
    );

    // APB answer: ready one cycle after setup, so no wait states
    always_comb
    begin
        pready_next = 1'b0;
        pslverr_next = pslverr_reg;
        prdata_next = prdata_reg;
        if (setup_phase)
        begin
            pready_next = 1'b1;
            pslverr_next = (sel == TMIF_SEL_NONE);
            prdata_next = `TMIF_WORD_ZERO;
            case (sel)
                TMIF_SEL_T0: prdata_next[7:0] = t0_flags;
                TMIF_SEL_T1: prdata_next[7:0] = t1_flags;
                TMIF_SEL_CTRL: prdata_next[`TMIF_BIT_GIE] = gie_reg;
                TMIF_SEL_STAT: prdata_next[3:0] = status_reg;
                TMIF_SEL_MASK: prdata_next[3:0] = mask_reg;
                default: prdata_next = `TMIF_WORD_ZERO;
            endcase
        end
    end

    // Register the bus answer
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= `TMIF_WORD_ZERO;
        end
        else
        begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
        end
    end

    // Match events in status order
    assign evt_vec[`TMIF_ST_T0_A] = t0_evt_i.cmp_a;
    assign evt_vec[`TMIF_ST_T0_P] = t0_evt_i.cmp_p;
    assign evt_vec[`TMIF_ST_T1_A] = t1_evt_i.cmp_a;
    assign evt_vec[`TMIF_ST_T1_P] = t1_evt_i.cmp_p;

    // Global enable, mask, and sticky status where a new event beats a clear
    always_comb
    begin
        gie_next = gie_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        if (wr_ctrl)
        begin
            gie_next = pwdata_i[`TMIF_BIT_GIE];
        end
        if (wr_mask)
        begin
            mask_next = pwdata_i[3:0];
        end
        if (wr_stat)
        begin
            status_next = status_reg & ~pwdata_i[3:0];
        end
        status_next = status_next | evt_vec;
    end

    // Register control, status and mask
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            gie_reg <= 1'b0;
            mask_reg <= `TMIF_EVT_RST;
            status_reg <= `TMIF_EVT_RST;
        end
        else
        begin
            gie_reg <= gie_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
        end
    end

    // Vector requests gated by enables and the global enable; summary from status and mask only
    always_comb
    begin
        t0_irq_next = vector_req(t0_flags, gie_reg);
        t1_irq_next = vector_req(t1_flags, gie_reg);
        irq_next = |(status_reg & mask_reg);
    end

    // Register the interrupt outputs
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            t0_irq_reg <= 1'b0;
            t1_irq_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            t0_irq_reg <= t0_irq_next;
            t1_irq_reg <= t1_irq_next;
            irq_reg <= irq_next;
        end
    end

    // Outputs straight from flip-flops
    assign prdata_o = prdata_reg;
    assign pready_o = pready_reg;
    assign pslverr_o = pslverr_reg;
    assign t0_irq_o = t0_irq_reg;
    assign t1_irq_o = t1_irq_reg;
    assign irq_o = irq_reg;

    // Checks on the flag bank
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A match pulse sets its flag whatever the enable
    chk_t0_a_set: assert property (t0_evt_i.cmp_a |=> t0_flags.cmp_a_request)
        else $error("timer 0 comparator A flag not set by match");
    chk_t0_p_set: assert property (t0_evt_i.cmp_p |=> t0_flags.cmp_p_request)
        else $error("timer 0 comparator P flag not set by match");
    chk_t1_a_set: assert property (t1_evt_i.cmp_a |=> t1_flags.cmp_a_request)
        else $error("timer 1 comparator A flag not set by match");
    chk_t1_p_set: assert property (t1_evt_i.cmp_p |=> t1_flags.cmp_p_request)
        else $error("timer 1 comparator P flag not set by match");

    // Enable bits follow a write to their register
    chk_t0_en_write: assert property (wr_t0 |=>
            (t0_flags.cmp_a_irq_en == $past(pwdata_i[`TMIF_BIT_EN_A]))
            && (t0_flags.cmp_p_irq_en == $past(pwdata_i[`TMIF_BIT_EN_P])))
        else $error("timer 0 enable bits did not take the write");
    chk_t1_en_write: assert property (wr_t1 |=>
            (t1_flags.cmp_a_irq_en == $past(pwdata_i[`TMIF_BIT_EN_A]))
            && (t1_flags.cmp_p_irq_en == $past(pwdata_i[`TMIF_BIT_EN_P])))
        else $error("timer 1 enable bits did not take the write");

    // Unimplemented bits read back as zero
    chk_unimpl_hi_zero: assert property (setup_phase && (sel inside {TMIF_SEL_T0, TMIF_SEL_T1})
            |=> prdata_o[7:6] == 2'h0)
        else $error("unimplemented bits 7 and 6 read nonzero");
    chk_unimpl_mid_zero: assert property (setup_phase && (sel inside {TMIF_SEL_T0, TMIF_SEL_T1})
            |=> prdata_o[3:2] == 2'h0)
        else $error("unimplemented bits 3 and 2 read nonzero");

    // Writing zero clears a pending flag when no match arrives with it
    chk_flag_clear: assert property (wr_t0 && !pwdata_i[`TMIF_BIT_REQ_A] && !t0_evt_i.cmp_a
            |=> !t0_flags.cmp_a_request)
        else $error("timer 0 comparator A flag not cleared by write");
    chk_t1_a_clear: assert property (wr_t1 && !pwdata_i[`TMIF_BIT_REQ_A] && !t1_evt_i.cmp_a
            |=> !t1_flags.cmp_a_request)
        else $error("timer 1 comparator A flag not cleared by write");
    chk_t1_p_clear: assert property (wr_t1 && !pwdata_i[`TMIF_BIT_REQ_P] && !t1_evt_i.cmp_p
            |=> !t1_flags.cmp_p_request)
        else $error("timer 1 comparator P flag not cleared by write");

    // A pending flag stays until software writes its register
    chk_t0_a_hold: assert property (t0_flags.cmp_a_request && !wr_t0
            |=> t0_flags.cmp_a_request)
        else $error("timer 0 comparator A flag dropped without a write");
    chk_t0_p_hold: assert property (t0_flags.cmp_p_request && !wr_t0
            |=> t0_flags.cmp_p_request)
        else $error("timer 0 comparator P flag dropped without a write");
    chk_t1_a_hold: assert property (t1_flags.cmp_a_request && !wr_t1
            |=> t1_flags.cmp_a_request)
        else $error("timer 1 comparator A flag dropped without a write");

    // Flags and enables are zero while reset is held
    chk_reset_clear: assert property (disable iff (1'b0) rst_i |->
            (t0_flags == `TMIF_FLAGS_RST) && (t1_flags == `TMIF_FLAGS_RST))
        else $error("flag registers not cleared by reset");

    // Vector request needs enable, flag and global enable
    chk_gie_gate: assert property (!gie_reg |=> !t0_irq_o && !t1_irq_o)
        else $error("vector request raised with global enable off");
    chk_irq_raise: assert property (gie_reg && t0_flags.cmp_a_request && t0_flags.cmp_a_irq_en
            |=> t0_irq_o)
        else $error("timer 0 vector request missing");
    chk_t1_irq_raise: assert property (gie_reg && t1_flags.cmp_p_request && t1_flags.cmp_p_irq_en
            |=> t1_irq_o)
        else $error("timer 1 vector request missing");
    chk_irq_masked: assert property (!t1_flags.cmp_a_irq_en && !t1_flags.cmp_p_irq_en |=> !t1_irq_o)
        else $error("timer 1 request raised with enables off");

    // Bus answers one cycle after setup and drops after the access
    chk_apb_ready: assert property (setup_phase |=> pready_o ##1 !pready_o)
        else $error("APB ready not a single cycle after setup");

    // An unmapped address answers with an error and zero data
    chk_apb_error: assert property (setup_phase && (sel == TMIF_SEL_NONE)
            |=> pslverr_o && (prdata_o == `TMIF_WORD_ZERO))
        else $error("unmapped address answered without error");

    // A write without the lane 0 strobe leaves the flags alone
    chk_no_strobe: assert property (psel_i && penable_i && pwrite_i && !pstrb_i[0] && (sel == TMIF_SEL_T0)
            && !t0_evt_i.cmp_a && !t0_evt_i.cmp_p |=> $stable(t0_flags))
        else $error("timer 0 flags changed by an unstrobed write");

    // Sticky status: set by any match, cleared by writing a one
    chk_status_set: assert property ((|evt_vec)
            |=> ((status_reg & $past(evt_vec)) == $past(evt_vec)))
        else $error("status bit not set by match");
    chk_status_clear: assert property (wr_stat && pwdata_i[`TMIF_ST_T0_A] && !evt_vec[`TMIF_ST_T0_A]
            |=> !status_reg[`TMIF_ST_T0_A])
        else $error("status bit not cleared by write of one");

    // Summary interrupt follows status and mask one cycle later
    chk_sum_irq: assert property (|(status_reg & mask_reg) |=> irq_o)
        else $error("summary interrupt missing for unmasked status");
    chk_sum_quiet: assert property (!(|(status_reg & mask_reg)) |=> !irq_o)
        else $error("summary interrupt raised with nothing unmasked");
endmodule // tmif_match_irq_bank
`default_nettype wire

// file: tb/tmif_timer_model.sv
// Partner model: the two comparators of one periodic timer.
// Assumes the bench requests matches on the rising edge of clk_i.
`timescale 1ns/100ps
`default_nettype none
module tmif_timer_model
    import tmif_pkg::*;
(
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Asynchronous reset, active high
    input wire logic [1:0] fire_i, // Bench request, bit1 comparator A, bit0 comparator P
    output var tmif_pkg::tmif_evt_t evt_o // Match pulses, one cycle per request cycle
);
    // Each match follows the request one clock later and lasts as many clocks as the request is held
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            evt_o <= '0;
        else
            evt_o <= '{cmp_a: fire_i[1], cmp_p: fire_i[0]};
    end
endmodule // tmif_timer_model
`default_nettype wire

// file: tb/tb.sv
// Self-checking bench of the timer match flag bank.
// Assumes the APB slave answers with pready_o and timers are modelled apart.
`timescale 1ns/100ps
`default_nettype none
`include "tmif_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
    import tmif_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b0;
    logic [11:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] fire0 = '0;
    logic [1:0] fire1 = '0;
    tmif_evt_t t0_evt;
    tmif_evt_t t1_evt;
    logic t0_irq;
    logic t1_irq;
    logic irq;
    logic [31:0] rd_v;
    logic er_v;
    int error_cnt = 0;
    int check_count = 0;

    // Clock at 40 MHz
    always #12.5 clk_i = ~clk_i;

    tmif_timer_model u_tm0 (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire0), .evt_o(t0_evt));
    tmif_timer_model u_tm1 (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire1), .evt_o(t1_evt));
    tmif_match_irq_bank u_dut (.clk_i(clk_i), .rst_i(rst_i), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .t0_evt_i(t0_evt),
        .t1_evt_i(t1_evt), .t0_irq_o(t0_irq), .t1_irq_o(t1_irq), .irq_o(irq));

    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            error_cnt++;
            $display("unexpected pready expected 1 seen timeout");
        end
        rd_v = prdata;
        er_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'hF);
    endtask

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'h0);
        `CHK(nm, {24'h00_0000, e}, rd_v)
    endtask

    // Request one match pulse of event i (status bit order), then let it land
    task automatic fire(input int i);
        @(posedge clk_i);
        if (i[1])
            fire1 <= i[0] ? 2'b01 : 2'b10;
        else
            fire0 <= i[0] ? 2'b01 : 2'b10;
        @(posedge clk_i);
        fire0 <= 2'b00;
        fire1 <= 2'b00;
        repeat (3) @(posedge clk_i);
    endtask

    task automatic test_reset();
        rdchk("t0 flags", `TMIF_OFF_T0_FLAGS, 8'h00);
        rdchk("t1 flags", `TMIF_OFF_T1_FLAGS, 8'h00);
        `CHK("irq lines", 3'b000, {t0_irq, t1_irq, irq})
        $display("test reset done");
    endtask

    task automatic test_fields();
        wr(`TMIF_OFF_T0_FLAGS, 32'h0000_00FF);
        rdchk("t0 fields", `TMIF_OFF_T0_FLAGS, 8'h33);
        wr(`TMIF_OFF_T1_FLAGS, 32'h0000_00FF);
        rdchk("t1 fields", `TMIF_OFF_T1_FLAGS, 8'h33);
        apb(1'b1, `TMIF_OFF_T0_FLAGS, 32'h0000_0000, 4'h0);
        rdchk("t0 no strobe", `TMIF_OFF_T0_FLAGS, 8'h33);
        wr(`TMIF_OFF_T0_FLAGS, 32'h0000_0000);
        rdchk("t0 cleared", `TMIF_OFF_T0_FLAGS, 8'h00);
        wr(`TMIF_OFF_T1_FLAGS, 32'h0000_0000);
        rdchk("t1 cleared", `TMIF_OFF_T1_FLAGS, 8'h00);
        apb(1'b0, 12'h014, 32'h0000_0000, 4'h0);
        `CHK("unmapped error", 1'b1, er_v)
        `CHK("unmapped data", 32'h0000_0000, rd_v)
        $display("test fields done");
    endtask

    // Every match of both timers: enabled, then disabled
    task automatic test_events();
        logic [11:0] a;
        logic [7:0] rq;
        logic [7:0] en;
        wr(`TMIF_OFF_CTRL, 32'h0000_0001);
        wr(`TMIF_OFF_MASK, 32'h0000_000F);
        for (int i = 0; i < 4; i++)
        begin
            a = i[1] ? `TMIF_OFF_T1_FLAGS : `TMIF_OFF_T0_FLAGS;
            rq = i[0] ? 8'h10 : 8'h20;
            en = i[0] ? 8'h01 : 8'h02;
            wr(a, {24'h00_0000, en});
            fire(i);
            rdchk("flag set", a, rq | en);
            @(negedge clk_i);
            `CHK("timer irq", {i[1], ~i[1]}, {t1_irq, t0_irq})
            `CHK("summary irq", 1'b1, irq)
            rdchk("status", `TMIF_OFF_STATUS, 8'h01 << i);
            wr(a, 32'h0000_0000);
            rdchk("flag cleared", a, 8'h00);
            wr(`TMIF_OFF_STATUS, 32'h0000_0001 << i);
            rdchk("status cleared", `TMIF_OFF_STATUS, 8'h00);
            repeat (2) @(negedge clk_i);
            `CHK("irq idle", 3'b000, {t0_irq, t1_irq, irq})
            fire(i);
            rdchk("flag while off", a, rq);
            `CHK("timer irq off", 2'b00, {t1_irq, t0_irq})
            wr(`TMIF_OFF_MASK, 32'h0000_000F ^ (32'h0000_0001 << i));
            repeat (2) @(negedge clk_i);
            `CHK("summary masked", 1'b0, irq)
            wr(`TMIF_OFF_MASK, 32'h0000_000F);
            wr(a, 32'h0000_0000);
            wr(`TMIF_OFF_STATUS, 32'h0000_000F);
        end
        wr(`TMIF_OFF_CTRL, 32'h0000_0000);
        wr(`TMIF_OFF_T0_FLAGS, 32'h0000_0022);
        repeat (2) @(negedge clk_i);
        `CHK("global off", 1'b0, t0_irq)
        wr(`TMIF_OFF_CTRL, 32'h0000_0001);
        repeat (2) @(negedge clk_i);
        `CHK("global on", 1'b1, t0_irq)
        wr(`TMIF_OFF_T0_FLAGS, 32'h0000_0000);
        $display("test events done");
    endtask

    // A match that lands on the edge of a clearing write must win
    task automatic test_collide();
        wr(`TMIF_OFF_T0_FLAGS, 32'h0000_0020);
        fork
            wr(`TMIF_OFF_T0_FLAGS, 32'h0000_0000);
            begin
                @(posedge clk_i);
                fire0 <= 2'b10;
                @(posedge clk_i);
                fire0 <= 2'b00;
            end
        join
        rdchk("flag beats clear", `TMIF_OFF_T0_FLAGS, 8'h20);
        fork
            wr(`TMIF_OFF_STATUS, 32'h0000_0001);
            begin
                @(posedge clk_i);
                fire0 <= 2'b10;
                @(posedge clk_i);
                fire0 <= 2'b00;
            end
        join
        rdchk("status beats clear", `TMIF_OFF_STATUS, 8'h01);
        wr(`TMIF_OFF_STATUS, 32'h0000_000F);
        wr(`TMIF_OFF_T0_FLAGS, 32'h0000_0000);
        rdchk("collide idle", `TMIF_OFF_T0_FLAGS, 8'h00);
        $display("test collide done");
    endtask

    // Reset in mid-run clears flags, enables, status, mask and global enable
    task automatic test_midreset();
        wr(`TMIF_OFF_T0_FLAGS, 32'h0000_0033);
        wr(`TMIF_OFF_T1_FLAGS, 32'h0000_0033);
        wr(`TMIF_OFF_CTRL, 32'h0000_0001);
        wr(`TMIF_OFF_MASK, 32'h0000_000F);
        fire(0);
        `CHK("irq before reset", 3'b111, {t0_irq, t1_irq, irq})
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        `CHK("irq in reset", 3'b000, {t0_irq, t1_irq, irq})
        rst_i <= 1'b0;
        rdchk("t0 after reset", `TMIF_OFF_T0_FLAGS, 8'h00);
        rdchk("t1 after reset", `TMIF_OFF_T1_FLAGS, 8'h00);
        rdchk("global after reset", `TMIF_OFF_CTRL, 8'h00);
        rdchk("status after reset", `TMIF_OFF_STATUS, 8'h00);
        rdchk("mask after reset", `TMIF_OFF_MASK, 8'h00);
        $display("test midreset done");
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        // Raise reset at time zero so every flop sees an edge before the first clock
        rst_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_fields();
        test_events();
        test_collide();
        test_midreset();
        conclude();
    end

    // Watchdog, far beyond the few hundred cycles the tests need
    initial
    begin
        #200_000;
        error_cnt++;
        conclude();
    end
endmodule // tb
`default_nettype wire
